//--- pkg/trc_pkg.sv
// shared constants and types for the reload/compare timer
package trc_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL   = 8'hc8;
   localparam logic [7:0] IDX_MODE   = 8'hc9;
   localparam logic [7:0] IDX_RCMP_L = 8'hca;
   localparam logic [7:0] IDX_RCMP_H = 8'hcb;
   localparam logic [7:0] IDX_CNT_L  = 8'hcc;
   localparam logic [7:0] IDX_CNT_H  = 8'hcd;
   localparam logic [7:0] IDX_STAT   = 8'hd0;
   localparam logic [7:0] IDX_MASK   = 8'hd1;
   localparam logic [7:0] IDX_IEN    = 8'hd2;
   localparam logic [7:0] IDX_CAP0_L = 8'he4;
   // control fields
   localparam int CTRL_FLAG_BIT = 7;
   localparam int CTRL_RUN_BIT  = 2;
   localparam int CTRL_MODE_BIT = 0;
   // mode fields
   localparam int MODE_RLD_EN_BIT = 7;
   localparam int MODE_DIV_LSB    = 4;
   localparam int MODE_CAPCLR_BIT = 3;
   localparam int MODE_MCLR_BIT   = 2;
   localparam int MODE_TRIG_LSB   = 0;
   // interrupt enable fields
   localparam int IEN_TIMER_BIT  = 0;
   localparam int IEN_GLOBAL_BIT = 7;
   // reset values
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [3:0]  RST_NIB  = 4'h0;
   localparam logic [8:0]  RST_PRE  = 9'h000;
   localparam logic [15:0] CNT_TOP  = 16'hffff;
   localparam int NUM_CAP = 3;
   localparam int PRE_W   = 9;

   typedef enum logic [1:0] {
      TRIG_OVF  = 2'b00,
      TRIG_CAP0 = 2'b01,
      TRIG_CAP1 = 2'b10,
      TRIG_CAP2 = 2'b11
   } trc_trig_t;

   typedef enum logic {
      MODE_RELOAD  = 1'b0,
      MODE_COMPARE = 1'b1
   } trc_mode_t;
endpackage

//--- core/trc_timer.sv
// 16-bit reload/compare timer with capture registers and apb slave
// Operation
// - 16-bit counter, low byte carries into high
// - prescaler ratios 1 to 512 by field
// - counts only while run; stop holds count except on a capture clear or capture reload
// - mode bit 0: reload, 1: compare
// - overflow or match sets flag, gated interrupt
// - reload enable copies reload value on event
// - trigger field picks overflow or capture
// - reload mode capture clear zeroes counter
// - capture clear suppresses reload on capture
// - compare mode match clear zeroes counter
// - reload/compare pair holds both values
// - three capture channels, own register pairs
// - counter bytes accessed separately; stop first
// - registers reset to zero
// - match when counter equals compare value
// - capture event copies running count
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module trc_timer (
   input  wire logic        mclk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [3:0]  pstrb_in,
   input  wire logic [2:0]  cap_event_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   output logic             timer_irq_out,
   output logic             irq_out
);

   function automatic logic hit(input logic [11:0] a,
                                input logic [7:0]  k);
      return (a[1:0] == 2'b00) && (a[11:10] == 2'b00) && (a[9:2] == k);
   endfunction

   function automatic logic [8:0] div_mask(input logic [2:0] s);
      unique case (s)
         3'h0: return 9'h000;
         3'h1: return 9'h003;
         3'h2: return 9'h00f;
         3'h3: return 9'h01f;
         3'h4: return 9'h03f;
         3'h5: return 9'h07f;
         3'h6: return 9'h0ff;
         3'h7: return 9'h1ff;
      endcase
   endfunction

   // trigger decode; the overflow code picks no capture channel
   function automatic logic cap_pick(input logic [1:0] t,
                                     input logic [2:0] ev);
      unique case (t)
         2'b00: return 1'b0;
         2'b01: return ev[0];
         2'b10: return ev[1];
         2'b11: return ev[2];
      endcase
   endfunction

   logic        run_reg;
   logic        mode_bit_reg;
   logic        flag_reg;
   logic [7:0]  mode_reg;
   logic [15:0] rcmp_reg;
   logic [15:0] cnt_reg;
   logic [15:0] cap_reg [0:2];
   logic [3:0]  stat_reg;
   logic [3:0]  mask_reg;
   logic [1:0]  ien_reg;
   logic [8:0]  pre_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic        tirq_reg;
   logic        irq_reg;

   // apb decode; one wait-free access after setup
   wire         setup    = psel_in & ~penable_in & ~pready_reg;
   wire         acc_wr   = psel_in & penable_in & pready_reg &
                           pwrite_in & pstrb_in[0];
   wire [7:0]   wdat     = pwdata_in[7:0];
   wire         wr_ctrl  = acc_wr & hit(paddr_in, trc_pkg::IDX_CTRL);
   wire         wr_mode  = acc_wr & hit(paddr_in, trc_pkg::IDX_MODE);
   wire         wr_rc_lo = acc_wr & hit(paddr_in, trc_pkg::IDX_RCMP_L);
   wire         wr_rc_hi = acc_wr & hit(paddr_in, trc_pkg::IDX_RCMP_H);
   wire         wr_cn_lo = acc_wr & hit(paddr_in, trc_pkg::IDX_CNT_L);
   wire         wr_cn_hi = acc_wr & hit(paddr_in, trc_pkg::IDX_CNT_H);
   wire         wr_stat  = acc_wr & hit(paddr_in, trc_pkg::IDX_STAT);
   wire         wr_mask  = acc_wr & hit(paddr_in, trc_pkg::IDX_MASK);
   wire         wr_ien   = acc_wr & hit(paddr_in, trc_pkg::IDX_IEN);
   wire         wr_cnt   = wr_cn_lo | wr_cn_hi;

   // mode fields
   wire         compare  = (mode_bit_reg == trc_pkg::MODE_COMPARE);
   wire         rld_en   = mode_reg[trc_pkg::MODE_RLD_EN_BIT];
   wire [2:0]   div_sel  = mode_reg[trc_pkg::MODE_DIV_LSB +: 3];
   wire         capclr   = mode_reg[trc_pkg::MODE_CAPCLR_BIT];
   wire         mclr     = mode_reg[trc_pkg::MODE_MCLR_BIT];
   wire [1:0]   trig     = mode_reg[trc_pkg::MODE_TRIG_LSB +: 2];

   // prescaler tick; only advances while running
   wire [8:0]   pmask    = div_mask(div_sel);
   wire         tick     = run_reg & ((pre_reg & pmask) == pmask);

   // counter events
   wire         ovf      = tick & (cnt_reg == trc_pkg::CNT_TOP);
   wire         match    = tick & compare & (cnt_reg == rcmp_reg);
   wire         cap_any  = |cap_event_in;
   wire         cap_clr  = ~compare & capclr & cap_any;
   // decoded by case so no channel index can fall out of range
   wire         trig_cap = cap_pick(trig, cap_event_in);
   wire         trig_hit = (trig == trc_pkg::TRIG_OVF) ? ovf : trig_cap;
   // capture clear overrides the reload on the same capture
   wire         reload   = ~compare & rld_en & ~cap_clr & trig_hit;
   wire         mclr_hit = match & mclr;
   wire [15:0]  cnt_inc  = cnt_reg + 16'h0001;
   wire [15:0]  cnt_hw   = cap_clr  ? trc_pkg::RST_WORD :
                           reload   ? rcmp_reg :
                           mclr_hit ? trc_pkg::RST_WORD :
                           tick     ? cnt_inc : cnt_reg;
   // byte writes replace one half only; a running count may tear
   wire [15:0]  cnt_next = wr_cn_lo ? {cnt_hw[15:8], wdat} :
                           wr_cn_hi ? {wdat, cnt_hw[7:0]} : cnt_hw;

   // flags: hardware set wins over a software clear
   wire         flag_set  = ovf | match;
   wire         flag_next = flag_set |
                            (wr_ctrl ? wdat[trc_pkg::CTRL_FLAG_BIT] : flag_reg);
   wire [3:0]   stat_set  = {cap_event_in, flag_set};
   wire [3:0]   stat_clr  = wr_stat ? wdat[3:0] : trc_pkg::RST_NIB;
   wire [3:0]   stat_next = stat_set | (stat_reg & ~stat_clr);

   // read mux; capture pairs sit at six consecutive indices
   wire [7:0]   ridx     = paddr_in[9:2];
   wire [7:0]   cap_off  = ridx - trc_pkg::IDX_CAP0_L;
   wire         cap_sel  = (paddr_in[1:0] == 2'b00) &&
                           (paddr_in[11:10] == 2'b00) &&
                           (ridx >= trc_pkg::IDX_CAP0_L) &&
                           (cap_off < 8'd6);
   logic [7:0]  rd_byte;
   logic        rd_ok;

   always_comb begin
      rd_byte = trc_pkg::RST_BYTE;
      rd_ok   = 1'b1;
      if (cap_sel) begin
         rd_byte = cap_off[0] ? cap_reg[cap_off[2:1]][15:8] :
                                cap_reg[cap_off[2:1]][7:0];
      end else if (hit(paddr_in, trc_pkg::IDX_CTRL)) begin
         rd_byte = {flag_reg, 4'h0, run_reg, 1'b0, mode_bit_reg};
      end else if (hit(paddr_in, trc_pkg::IDX_MODE)) begin
         rd_byte = mode_reg;
      end else if (hit(paddr_in, trc_pkg::IDX_RCMP_L)) begin
         rd_byte = rcmp_reg[7:0];
      end else if (hit(paddr_in, trc_pkg::IDX_RCMP_H)) begin
         rd_byte = rcmp_reg[15:8];
      end else if (hit(paddr_in, trc_pkg::IDX_CNT_L)) begin
         rd_byte = cnt_reg[7:0];
      end else if (hit(paddr_in, trc_pkg::IDX_CNT_H)) begin
         rd_byte = cnt_reg[15:8];
      end else if (hit(paddr_in, trc_pkg::IDX_STAT)) begin
         rd_byte = {4'h0, stat_reg};
      end else if (hit(paddr_in, trc_pkg::IDX_MASK)) begin
         rd_byte = {4'h0, mask_reg};
      end else if (hit(paddr_in, trc_pkg::IDX_IEN)) begin
         rd_byte = {ien_reg[1], 6'h00, ien_reg[0]};
      end else begin
         rd_ok = 1'b0;
      end
   end

   // bus answer
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= setup;
         pslverr_reg <= setup & ~rd_ok;
         if (setup) begin
            prdata_reg <= {24'h00_0000, rd_byte};
         end
      end
   end

   // control and configuration
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         run_reg      <= 1'b0;
         mode_bit_reg <= 1'b0;
         flag_reg     <= 1'b0;
         mode_reg     <= trc_pkg::RST_BYTE;
         rcmp_reg     <= trc_pkg::RST_WORD;
         mask_reg     <= trc_pkg::RST_NIB;
         ien_reg      <= 2'b00;
      end else begin
         flag_reg <= flag_next;
         if (wr_ctrl) begin
            run_reg      <= wdat[trc_pkg::CTRL_RUN_BIT];
            mode_bit_reg <= wdat[trc_pkg::CTRL_MODE_BIT];
         end
         if (wr_mode) begin
            mode_reg <= wdat;
         end
         if (wr_rc_lo) begin
            rcmp_reg[7:0] <= wdat;
         end
         if (wr_rc_hi) begin
            rcmp_reg[15:8] <= wdat;
         end
         if (wr_mask) begin
            mask_reg <= wdat[3:0];
         end
         if (wr_ien) begin
            ien_reg <= {wdat[trc_pkg::IEN_GLOBAL_BIT],
                        wdat[trc_pkg::IEN_TIMER_BIT]};
         end
      end
   end

   // counter, prescaler, status, interrupts
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cnt_reg  <= trc_pkg::RST_WORD;
         pre_reg  <= trc_pkg::RST_PRE;
         stat_reg <= trc_pkg::RST_NIB;
         tirq_reg <= 1'b0;
         irq_reg  <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         stat_reg <= stat_next;
         // restart the divider on a mode write so a new ratio starts clean
         if (wr_mode) begin
            pre_reg <= trc_pkg::RST_PRE;
         end else if (run_reg) begin
            pre_reg <= pre_reg + 9'h001;
         end
         tirq_reg <= flag_reg & ien_reg[0] & ien_reg[1];
         irq_reg  <= |(stat_reg & mask_reg);
      end
   end

   // capture pairs; a capture event wins over a software write
   for (genvar n = 0; n < trc_pkg::NUM_CAP; n++) begin : g_cap
      wire [7:0] lo_idx = trc_pkg::IDX_CAP0_L + 8'(2 * n);
      wire       wr_lo  = acc_wr & hit(paddr_in, lo_idx);
      wire       wr_hi  = acc_wr & hit(paddr_in, lo_idx + 8'd1);
      always_ff @(posedge mclk_in or posedge sys_rst_in) begin
         if (sys_rst_in) begin
            cap_reg[n] <= trc_pkg::RST_WORD;
         end else if (cap_event_in[n]) begin
            cap_reg[n] <= cnt_reg;
         end else if (wr_lo) begin
            cap_reg[n][7:0] <= wdat;
         end else if (wr_hi) begin
            cap_reg[n][15:8] <= wdat;
         end
      end
   end

   assign prdata_out    = prdata_reg;
   assign pready_out    = pready_reg;
   assign pslverr_out   = pslverr_reg;
   assign timer_irq_out = tirq_reg;
   assign irq_out       = irq_reg;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);

   wire plain_step = tick & ~cap_clr & ~reload & ~mclr_hit & ~wr_cnt;

   a_low_carry_high: assert property (
      plain_step && cnt_reg[7:0] == 8'hff |=>
         cnt_reg[15:8] == $past(cnt_reg[15:8]) + 8'h01 &&
         cnt_reg[7:0] == 8'h00)
      else $error("low byte did not carry into high byte");
   a_undivided_tick: assert property (
      run_reg && div_sel == 3'd0 |-> tick)
      else $error("divider 1/1 failed to tick every cycle");
   a_stop_holds_count: assert property (
      !run_reg && !cap_any && !wr_cnt |=> $stable(cnt_reg))
      else $error("count moved while stopped");
   a_flag_on_event: assert property (
      ovf || match |=> flag_reg ##1 flag_reg || !$past(wr_ctrl))
      else $error("timer flag not set by overflow or match");
   a_timer_irq_gate: assert property (
      flag_reg && ien_reg == 2'b11 |=> timer_irq_out)
      else $error("timer interrupt not raised");
   a_reload_copies: assert property (
      reload && !wr_cnt |=> cnt_reg == $past(rcmp_reg))
      else $error("reload value not loaded");
   a_overflow_wraps: assert property (
      ovf && !compare && (!rld_en || trig != 2'b00) &&
      !cap_clr && !reload && !wr_cnt |=> cnt_reg == 16'h0000)
      else $error("counter did not wrap to zero");
   a_capture_clears: assert property (
      cap_clr && !wr_cnt |=> cnt_reg == 16'h0000)
      else $error("capture did not clear counter");
   a_match_clears: assert property (
      match && mclr && !wr_cnt |=> cnt_reg == 16'h0000)
      else $error("match did not clear counter");
   a_capture_copy: assert property (
      cap_event_in[1] |=> cap_reg[1] == $past(cnt_reg))
      else $error("capture 1 missed the count");
   a_sw_byte_write: assert property (
      wr_cn_lo |=> cnt_reg[7:0] == $past(wdat))
      else $error("counter low byte write lost");
   a_reset_zero: assert property (
      $past(sys_rst_in) |-> cnt_reg == 16'h0000 && mode_reg == 8'h00)
      else $error("registers not zero after reset");


   // a capture that is also the reload trigger must still clear
   a_clear_beats_reload: assert property (
      cap_clr && rld_en && trig_cap && !wr_cnt |=> cnt_reg == 16'h0000)
      else $error("capture clear let a reload through");
   a_plain_increment: assert property (
      tick && !cap_clr && !reload && !mclr_hit && !wr_cnt |=>
         cnt_reg == 16'($past(cnt_reg) + 16'h0001))
      else $error("counter did not step by one");
   // capture clear and capture reload belong to reload mode only
   a_compare_ignores_cap: assert property (
      compare && !tick && !wr_cnt |=> $stable(cnt_reg))
      else $error("capture changed the count in compare mode");
   a_match_sets_flag: assert property (
      compare && tick && cnt_reg == rcmp_reg |=> flag_reg)
      else $error("compare match did not set the flag");
   a_flag_sticky: assert property (
      flag_reg && !wr_ctrl |=> flag_reg)
      else $error("timer flag cleared by hardware");

   // interrupt outputs lag their sources by one registered cycle
   a_timer_irq_low: assert property (
      !(flag_reg && ien_reg == 2'b11) |=> !timer_irq_out)
      else $error("timer interrupt without enabled flag");
   a_irq_follows_mask: assert property (
      (|(stat_reg & mask_reg)) |=> irq_out)
      else $error("interrupt missing for unmasked status");

   a_capture0_hold: assert property (
      !cap_event_in[0] && !acc_wr |=> $stable(cap_reg[0]))
      else $error("capture 0 changed without event or write");
   a_capture_status: assert property (
      cap_event_in[2] |=> stat_reg[3])
      else $error("capture 2 status bit not set");
   // zero wait states: ready never stands two cycles
   a_ready_pulse: assert property (
      pready_out |=> !pready_out)
      else $error("ready stood longer than one cycle");

   c_overflow: cover property (ovf && !compare);
   c_slowest_tick: cover property (tick && div_sel == 3'd7);
   c_match_clear: cover property (match && mclr);
   c_capture_clear: cover property (cap_clr);
   c_capture_reload: cover property (reload && trig != 2'b00);
endmodule

//--- tb/trc_cap_src.sv
// capture event source: one-cycle event after a chosen delay
`timescale 1ns/1ps
module trc_cap_src (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic [1:0] ch_in,
   input  wire logic       fire_in,
   input  wire logic [3:0] dly_in,
   output logic      [2:0] cap_out
);
   logic [4:0] cnt_reg;
   logic [1:0] ch_reg;
   // a zero delay still answers on the next edge, never in the same one
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_reg <= 5'h00;
         ch_reg  <= 2'h0;
         cap_out <= 3'h0;
      end else if (fire_in) begin
         cnt_reg <= {1'b0, dly_in} + 5'h01;
         ch_reg  <= ch_in;
         cap_out <= 3'h0;
      end else begin
         cap_out <= (cnt_reg == 5'h01) ? (3'h1 << ch_reg) : 3'h0;
         if (cnt_reg != 5'h00)
            cnt_reg <= cnt_reg - 5'h01;
      end
   end
endmodule

//--- tb/trc_timer_tb_top.sv
// self-checking bench for the reload/compare timer
`timescale 1ns/1ps
module trc_timer_tb_top;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pw = 1'b0;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd;
   logic        prdy;
   logic        perr;
   logic        tirq;
   logic        irq;
   logic [2:0]  cap;
   logic [1:0]  ch = 2'h0;
   logic        fire = 1'b0;
   logic [3:0]  dly = 4'h0;
   integer      seed = 32'h903c;
   int          miscompares = 0;
   int          n_checks = 0;
   int          ratio [8] = '{1, 4, 16, 32, 64, 128, 256, 512};
   bit   [15:0] m_cnt;
   bit   [15:0] m_rc;
   bit   [15:0] old;
   bit          m_flag;
   bit          cm;
   bit   [7:0]  md;
   logic [7:0]  r;
   logic        e;
   logic [15:0] v;

   always #50 mclk = ~mclk;

   trc_timer i_dut (.mclk_in(mclk), .sys_rst_in(rst), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pw), .paddr_in(pa), .pwdata_in(pwd),
      .pstrb_in(4'h1), .cap_event_in(cap), .prdata_out(prd),
      .pready_out(prdy), .pslverr_out(perr), .timer_irq_out(tirq),
      .irq_out(irq));
   trc_cap_src i_src (.clk_in(mclk), .rst_in(rst), .ch_in(ch),
      .fire_in(fire), .dly_in(dly), .cap_out(cap));

   task chk(input string n, input logic [15:0] x, input logic [15:0] g);
      n_checks++;
      if (g !== x) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, x, g);
      end
   endtask

   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task apb(input bit w, input logic [7:0] i, input logic [7:0] d);
      int k;
      @(posedge mclk);
      psel <= 1'b1;
      pen  <= 1'b0;
      pw   <= w;
      pa   <= {2'b00, i, 2'b00};
      pwd  <= {24'h0, d};
      @(posedge mclk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (prdy !== 1'b1 && k < 50);
      if (k >= 50)
         chk("pready", 16'h1, 16'h0);
      r = prd[7:0];
      e = perr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask

   // counter bytes only touched while stopped: a running count may tear
   task set_cnt(input bit [15:0] x);
      apb(1'b1, trc_pkg::IDX_CNT_L, x[7:0]);
      apb(1'b1, trc_pkg::IDX_CNT_H, x[15:8]);
      m_cnt = x;
   endtask

   task rd_cnt;
      apb(1'b0, trc_pkg::IDX_CNT_L, 8'h00);
      v[7:0] = r;
      apb(1'b0, trc_pkg::IDX_CNT_H, 8'h00);
      v[15:8] = r;
      chk("count", m_cnt, v);
   endtask

   task set_rc(input bit [15:0] x);
      apb(1'b1, trc_pkg::IDX_RCMP_L, x[7:0]);
      apb(1'b1, trc_pkg::IDX_RCMP_H, x[15:8]);
      m_rc = x;
   endtask

   function void step();
      if (cm && m_cnt == m_rc) begin
         m_flag = 1'b1;
         m_cnt = md[2] ? 16'h0000 : m_cnt + 16'h1;
      end else if (m_cnt == 16'hffff) begin
         m_flag = 1'b1;
         m_cnt = (!cm && md[7]) ? m_rc : 16'h0000;
      end else
         m_cnt = m_cnt + 16'h1;
   endfunction

   // stop write carries the expected flag so a late set is not lost
   task run_for(input int w);
      apb(1'b1, trc_pkg::IDX_MODE, md);
      apb(1'b1, trc_pkg::IDX_CTRL, {5'h0, 1'b1, 1'b0, cm});
      repeat (w) @(posedge mclk);
      // run stands from the edge after the start write to the stop edge
      repeat ((w + 3) / ratio[md[6:4]]) step();
      apb(1'b1, trc_pkg::IDX_CTRL, {m_flag, 6'h0, cm});
   endtask

   task settle;
      repeat (2) @(posedge mclk);
      #1;
   endtask

   initial begin
      #3_000_000;
      miscompares++;
      end_sim;
   end

   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 'hc8; i <= 'hcd; i++) begin
         apb(1'b0, i[7:0], 8'h00);
         chk("reset value", 16'h0, {8'h0, r});
      end
      apb(1'b0, 8'h00, 8'h00);
      chk("unmapped error", 16'h1, {15'h0, e});
      $display("test reset done");
      cm = 1'b0;
      for (int d = 0; d < 8; d++) begin
         md = {1'b0, d[2:0], 4'h0};
         set_cnt(16'h0000);
         run_for(1100 + $unsigned($random(seed)) % 400);
         rd_cnt;
      end
      $display("test prescale done");
      set_rc(16'hfff0);
      for (int l = 0; l < 2; l++) begin
         apb(1'b1, trc_pkg::IDX_CTRL, 8'h00);
         m_flag = 1'b0;
         md = {l[0], 7'h0};
         set_cnt(16'hfff8);
         run_for(20);
         rd_cnt;
         apb(1'b0, trc_pkg::IDX_CTRL, 8'h00);
         chk("control", {8'h0, m_flag, 7'h0}, {8'h0, r});
      end
      apb(1'b0, trc_pkg::IDX_STAT, 8'h00);
      chk("status timer", 16'h1, {15'h0, r[0]});
      apb(1'b1, trc_pkg::IDX_IEN, 8'h81);
      apb(1'b1, trc_pkg::IDX_MASK, 8'h00);
      settle;
      chk("irq masked", 16'h0, {15'h0, irq});
      chk("timer irq", 16'h1, {15'h0, tirq});
      apb(1'b1, trc_pkg::IDX_MASK, 8'h01);
      settle;
      chk("irq unmasked", 16'h1, {15'h0, irq});
      apb(1'b1, trc_pkg::IDX_STAT, 8'h01);
      settle;
      chk("irq cleared", 16'h0, {15'h0, irq});
      apb(1'b1, trc_pkg::IDX_CTRL, 8'h00);
      settle;
      chk("timer irq off", 16'h0, {15'h0, tirq});
      $display("test overflow done");
      set_rc(16'h0040);
      cm = 1'b1;
      for (int mc = 0; mc < 2; mc++) begin
         apb(1'b1, trc_pkg::IDX_CTRL, 8'h00);
         m_flag = 1'b0;
         md = {5'h0, mc[0], 2'b00};
         set_cnt(16'h0000);
         run_for(150);
         rd_cnt;
         apb(1'b0, trc_pkg::IDX_CTRL, 8'h00);
         chk("match flag", {8'h0, m_flag, 6'h0, cm}, {8'h0, r});
      end
      $display("test compare done");
      cm = 1'b0;
      apb(1'b1, trc_pkg::IDX_CTRL, 8'h00);
      for (int n = 0; n < 3; n++) begin
         set_rc(16'($random(seed)));
         set_cnt(16'($random(seed)));
         old = m_cnt;
         md = 8'h80 | ((n == 2) ? 8'h08 : 8'h00) | 8'(n + 1);
         apb(1'b1, trc_pkg::IDX_MODE, md);
         ch   <= n[1:0];
         dly  <= 4'($random(seed));
         fire <= 1'b1;
         @(posedge mclk);
         fire <= 1'b0;
         repeat (20) @(posedge mclk);
         apb(1'b0, 8'(trc_pkg::IDX_CAP0_L + 2 * n), 8'h00);
         v[7:0] = r;
         apb(1'b0, 8'(trc_pkg::IDX_CAP0_L + 2 * n + 1), 8'h00);
         v[15:8] = r;
         chk("capture", old, v);
         m_cnt = (n == 2) ? 16'h0000 : m_rc;
         rd_cnt;
         apb(1'b0, trc_pkg::IDX_STAT, 8'h00);
         chk("status capture", 16'h1, {15'h0, r[n + 1]});
      end
      $display("test capture done");
      end_sim;
   end
endmodule
